/* rtl/fbe_erase_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fbe_regs.svh"
module fbe_erase_ctrl (
	input wire logic mclk,
	input wire logic reset,
	input wire logic start,
	input wire logic [21:0] block_addr,
	input wire logic last_block,
	input wire logic check_each,
	input wire logic check_protect,
	input wire logic clear_req,
	output logic busy,
	output logic done,
	output var logic [7:0] status_reg,
	output var logic err_supply_reg,
	output var logic err_protect_reg,
	output var logic err_sequence_reg,
	output var logic err_erase_reg,
	output var logic [21:0] flash_addr_reg,
	output var logic [7:0] flash_dq_out_reg,
	input wire logic [7:0] flash_dq_in,
	output logic flash_dq_oe,
	output var logic flash_ce_n_reg,
	output var logic flash_we_n_reg,
	output var logic flash_oe_n_reg
);
	fbe_pkg::fbe_state_t state_reg, state_next;
	logic [`FBE_CNT_W-1:0] cnt_reg;
	logic phase_reg;
	logic [7:0] dq_s1_reg, dq_s2_reg;
	logic pending_reg;
	logic cycle_end;
	logic is_write;
	logic sr_ready;
	logic sr_any_err;
	logic err_seen;

	// Bus cycle ends when the strobe has been held long enough in its second phase.
	assign cycle_end = phase_reg && (cnt_reg == `FBE_CNT_W'(`FBE_STROBE_CYC));
	assign is_write = (state_reg != fbe_pkg::FBE_POLL) && (state_reg != fbe_pkg::FBE_IDLE)
		&& (state_reg != fbe_pkg::FBE_DONE);
	assign sr_ready = dq_s2_reg[`FBE_SR_READY];
	assign sr_any_err = dq_s2_reg[`FBE_SR_ERASE_ERR] | dq_s2_reg[`FBE_SR_SEQ_ERR]
		| dq_s2_reg[`FBE_SR_SUPPLY_ERR] | (check_protect & dq_s2_reg[`FBE_SR_PROTECT]);
	assign err_seen = err_supply_reg | err_protect_reg | err_sequence_reg | err_erase_reg;
	assign busy = (state_reg != fbe_pkg::FBE_IDLE);
	assign done = (state_reg == fbe_pkg::FBE_DONE);
	assign flash_dq_oe = is_write && !flash_we_n_reg;

	// Next state of the command sequencer.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			fbe_pkg::FBE_IDLE: begin
				if (clear_req) begin
					state_next = fbe_pkg::FBE_CLEAR;
				end else if (start && !err_seen) begin
					state_next = fbe_pkg::FBE_SETUP;
				end
			end
			fbe_pkg::FBE_SETUP: if (cycle_end) state_next = fbe_pkg::FBE_CONFIRM;
			fbe_pkg::FBE_CONFIRM: if (cycle_end) state_next = fbe_pkg::FBE_RDSR;
			fbe_pkg::FBE_RDSR: if (cycle_end) state_next = fbe_pkg::FBE_POLL;
			fbe_pkg::FBE_POLL: begin
				if (cycle_end && sr_ready) begin
					if (pending_reg) begin
						state_next = fbe_pkg::FBE_ARRAY;
					end else begin
						state_next = fbe_pkg::FBE_DONE;
					end
				end
			end
			fbe_pkg::FBE_CLEAR: if (cycle_end) state_next = fbe_pkg::FBE_DONE;
			fbe_pkg::FBE_ARRAY: if (cycle_end) state_next = fbe_pkg::FBE_DONE;
			fbe_pkg::FBE_DONE: state_next = fbe_pkg::FBE_IDLE;
			default: state_next = fbe_pkg::FBE_IDLE;
		endcase
	end

	// Data driven on the bus in each write state.
	logic [7:0] cmd_code;
	assign cmd_code = (state_reg == fbe_pkg::FBE_SETUP) ? `FBE_CMD_ERASE_SETUP :
		(state_reg == fbe_pkg::FBE_CONFIRM) ? `FBE_CMD_ERASE_CONFIRM :
		(state_reg == fbe_pkg::FBE_RDSR) ? `FBE_CMD_READ_STATUS :
		(state_reg == fbe_pkg::FBE_CLEAR) ? `FBE_CMD_CLEAR_STATUS : `FBE_CMD_READ_ARRAY;

	// State, strobe phase and cycle counter; each bus cycle is setup then strobe.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_reg <= fbe_pkg::FBE_IDLE;
			cnt_reg <= '0;
			phase_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_next != state_reg || state_reg == fbe_pkg::FBE_IDLE || cycle_end) begin
				cnt_reg <= '0;
				phase_reg <= 1'b0;
			end else if (!phase_reg) begin
				phase_reg <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + `FBE_CNT_W'(1);
			end
		end
	end

	// Bus pins: address and data set up one cycle before the strobe falls.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			flash_ce_n_reg <= 1'b1;
			flash_we_n_reg <= 1'b1;
			flash_oe_n_reg <= 1'b1;
			flash_addr_reg <= '0;
			flash_dq_out_reg <= 8'h00;
		end else begin
			flash_addr_reg <= block_addr;
			flash_dq_out_reg <= cmd_code;
			flash_ce_n_reg <= !(busy && !done && phase_reg && !cycle_end);
			flash_we_n_reg <= !(is_write && phase_reg && !cycle_end);
			flash_oe_n_reg <= !((state_reg == fbe_pkg::FBE_POLL) && phase_reg && !cycle_end);
		end
	end

	// Status pin data passes two flip-flops before use.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			dq_s1_reg <= 8'h00;
			dq_s2_reg <= 8'h00;
		end else begin
			dq_s1_reg <= flash_dq_in;
			dq_s2_reg <= dq_s1_reg;
		end
	end

	// Captured status and sticky error copies; clear only on a finished clear command.
	logic take_status;
	logic do_clear;
	assign take_status = (state_reg == fbe_pkg::FBE_POLL) && cycle_end && sr_ready
		&& (check_each || pending_reg);
	assign do_clear = (state_reg == fbe_pkg::FBE_CLEAR) && cycle_end;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			status_reg <= 8'h80;
			err_supply_reg <= 1'b0;
			err_protect_reg <= 1'b0;
			err_sequence_reg <= 1'b0;
			err_erase_reg <= 1'b0;
			pending_reg <= 1'b0;
		end else begin
			if (state_reg == fbe_pkg::FBE_IDLE && start) begin
				pending_reg <= last_block;
			end
			if (do_clear) begin
				status_reg <= 8'h80;
				err_supply_reg <= 1'b0;
				err_protect_reg <= 1'b0;
				err_sequence_reg <= 1'b0;
				err_erase_reg <= 1'b0;
			end else if (take_status) begin
				status_reg <= dq_s2_reg;
				err_supply_reg <= err_supply_reg | dq_s2_reg[`FBE_SR_SUPPLY_ERR];
				err_protect_reg <= err_protect_reg | (check_protect & dq_s2_reg[`FBE_SR_PROTECT]);
				err_sequence_reg <= err_sequence_reg
					| (dq_s2_reg[`FBE_SR_SEQ_ERR] & dq_s2_reg[`FBE_SR_ERASE_ERR]);
				err_erase_reg <= err_erase_reg
					| (dq_s2_reg[`FBE_SR_ERASE_ERR] & !dq_s2_reg[`FBE_SR_SEQ_ERR]);
			end
		end
	end

	// Setup is always followed by confirm in the very next cycle.
	setup_confirm_a: assert property (@(posedge mclk) disable iff (reset)
		(state_reg == fbe_pkg::FBE_SETUP && cycle_end) |=> state_reg == fbe_pkg::FBE_CONFIRM)
		else $error("confirm did not follow setup");
	// No new erase starts while errors are held.
	err_block_a: assert property (@(posedge mclk) disable iff (reset)
		(state_reg == fbe_pkg::FBE_IDLE && err_seen && !clear_req) |=> state_reg != fbe_pkg::FBE_SETUP)
		else $error("erase started with errors pending");
	// The sticky erase error flag only falls through a clear.
	sticky_err_a: assert property (@(posedge mclk) disable iff (reset)
		$fell(err_erase_reg) |-> $past(do_clear))
		else $error("error flag dropped without clear");
	// Poll leaves only when ready was read.
	ready_poll_a: assert property (@(posedge mclk) disable iff (reset)
		(state_reg == fbe_pkg::FBE_POLL && state_next != fbe_pkg::FBE_POLL) |-> sr_ready)
		else $error("left poll while busy");
	// Data bus driven only in write states, never against a read strobe.
	dq_drive_a: assert property (@(posedge mclk) disable iff (reset)
		flash_dq_oe |-> !flash_we_n_reg && flash_oe_n_reg && state_reg != fbe_pkg::FBE_POLL)
		else $error("data driven outside a write");
	// Write and read strobes never overlap.
	strobe_excl_a: assert property (@(posedge mclk) disable iff (reset)
		!(!flash_we_n_reg && !flash_oe_n_reg))
		else $error("write and read strobes overlap");
	// Every strobe lies inside a chip select.
	strobe_ce_a: assert property (@(posedge mclk) disable iff (reset)
		(!flash_we_n_reg || !flash_oe_n_reg) |-> !flash_ce_n_reg)
		else $error("strobe without chip select");
	// A captured status word always shows the ready bit.
	status_ready_a: assert property (@(posedge mclk) disable iff (reset)
		take_status |=> status_reg[`FBE_SR_READY])
		else $error("captured status not ready");
	// A finished clear leaves every error flag low and the status word at ready.
	clear_flags_a: assert property (@(posedge mclk) disable iff (reset)
		do_clear |=> !err_seen && status_reg == 8'h80)
		else $error("flags still set after clear");
	// A captured error bit other than a lone sequence bit always raises at least one sticky flag.
	err_capture_a: assert property (@(posedge mclk) disable iff (reset)
		(take_status && sr_any_err) |=> err_seen)
		else $error("status error not held");
endmodule : fbe_erase_ctrl
`default_nettype wire

/* rtl/fbe_regs.svh */
`ifndef FBE_REGS_SVH
`define FBE_REGS_SVH
// Command codes written on the flash data bus.
`define FBE_CMD_READ_STATUS 8'h70
`define FBE_CMD_ERASE_SETUP 8'h20
`define FBE_CMD_ERASE_CONFIRM 8'hd0
`define FBE_CMD_CLEAR_STATUS 8'h50
`define FBE_CMD_READ_ARRAY 8'hff
// Status word bit positions.
`define FBE_SR_READY 7
`define FBE_SR_ERASE_ERR 5
`define FBE_SR_SEQ_ERR 4
`define FBE_SR_SUPPLY_ERR 3
`define FBE_SR_PROTECT 1
// Bus cycle timing: strobe low time in ns, rounded up to whole 10 ns mclk cycles.
`define FBE_STROBE_NS 70
`define FBE_STROBE_CYC ((`FBE_STROBE_NS + 9) / 10)
`define FBE_CNT_W 4
`endif

/* rtl/fbe_pkg.sv */
package fbe_pkg;
	// Sequencer states, Gray coded along the usual path.
	typedef enum logic [3:0] {
		FBE_IDLE = 4'h0,
		FBE_SETUP = 4'h1,
		FBE_CONFIRM = 4'h3,
		FBE_RDSR = 4'h2,
		FBE_POLL = 4'h6,
		FBE_CLEAR = 4'h7,
		FBE_ARRAY = 4'h5,
		FBE_DONE = 4'h4
	} fbe_state_t;
endpackage : fbe_pkg

/* verif/fbe_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Flash device: takes commands at the write strobe's rising edge and answers reads with status or array data.
module fbe_flash_model (
	input wire logic mclk,
	input wire logic [2:0] fault,
	input wire logic [7:0] dq,
	output logic [7:0] dq_in,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	output logic [7:0] last_cmd,
	output int erases
);
	logic [7:0] sr = 8'h80, prev = 8'h00, held = 8'h00;
	logic show_sr = 1'b0, we_d = 1'b1, ce_d = 1'b1;
	int wait_cnt = 0;
	wire rd = !ce_n && !oe_n;
	// An unselected or idle bus shows the inverse of its last value.
	assign dq_in = rd ? (show_sr ? sr : 8'hff) : ~held;
	// Erase timing, error flags and command decode.
	always @(posedge mclk) begin
		we_d <= we_n;
		ce_d <= ce_n;
		if (rd) held <= dq_in;
		if (wait_cnt > 1) wait_cnt <= wait_cnt - 1;
		else if (wait_cnt == 1) begin
			wait_cnt <= 0;
			sr <= sr | {1'b1, 1'b0, fault == 3'd3 || fault == 3'd4, fault == 3'd4, fault == 3'd1, 1'b0, fault == 3'd2, 1'b0};
		end
		if (we_n && !we_d && !ce_d) begin
			last_cmd <= dq;
			prev <= dq;
			show_sr <= dq != 8'hff;
			if (dq == 8'h50) sr <= 8'h80;
			if (dq == 8'hd0 && prev == 8'h20) begin
				sr[7] <= 1'b0;
				wait_cnt <= 5 + $urandom_range(30);
				erases <= erases + 1;
			end
		end
	end
	initial erases = 0;
endmodule : fbe_flash_model
`default_nettype wire

/* verif/flash_block_erase_status_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_block_erase_status_bench;
	logic mclk = 0, reset = 1, start = 0, last_block = 0, check_each = 0, check_protect = 0, clear_req = 0;
	logic [21:0] block_addr = 22'h0, faddr;
	logic busy, done, oe, ce_n, we_n, oe_n, e_sup, e_pro, e_seq, e_era;
	logic [7:0] status_reg, dq_out, dq_in, last_cmd;
	logic [2:0] fault = 3'd0;
	int erases, error_cnt = 0, checked = 0, n0, bad_drive = 0;
	// The clock toggles every half period.
	always #5 mclk = ~mclk;
	// Counts cycles where a write strobe lacks bus drive or the bus is driven during a read.
	always @(negedge mclk) begin
		if (!reset && ((!we_n && !oe) || (oe && !oe_n))) bad_drive++;
	end
	fbe_erase_ctrl fbe_erase_ctrl_i (.mclk(mclk), .reset(reset), .start(start), .block_addr(block_addr),
		.last_block(last_block), .check_each(check_each), .check_protect(check_protect), .clear_req(clear_req),
		.busy(busy), .done(done), .status_reg(status_reg), .err_supply_reg(e_sup), .err_protect_reg(e_pro),
		.err_sequence_reg(e_seq), .err_erase_reg(e_era), .flash_addr_reg(faddr), .flash_dq_out_reg(dq_out),
		.flash_dq_in(dq_in), .flash_dq_oe(oe), .flash_ce_n_reg(ce_n), .flash_we_n_reg(we_n), .flash_oe_n_reg(oe_n));
	fbe_flash_model fbe_flash_model_i (.mclk(mclk), .fault(fault), .dq(dq_out), .dq_in(dq_in), .ce_n(ce_n),
		.we_n(we_n), .oe_n(oe_n), .last_cmd(last_cmd), .erases(erases));
	// Status word the device should hold after the given faults.
	function automatic logic [7:0] exp_sr(input logic [2:0] f);
		exp_sr = {2'b10, f == 3'd3 || f == 3'd4, f == 3'd4, f == 3'd1, 1'b0, f == 3'd2, 1'b0};
	endfunction : exp_sr
	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	// Pulses one request, then waits at falling edges for done or for idle.
	task automatic run(input logic clr, input logic want_done);
		int n;
		start = !clr;
		clear_req = clr;
		@(negedge mclk);
		start = 0;
		clear_req = 0;
		for (n = 0; n < 5000; n++) begin
			if (want_done ? done === 1'b1 : busy === 1'b0) break;
			@(negedge mclk);
		end
		if (n == 5000) begin
			error_cnt++;
			wrap_up();
		end
		@(negedge mclk);
	endtask : run
	// Erase with one fault, check captured flags, refused start, then clear.
	task automatic erase_one(input logic [2:0] f);
		fault = f;
		block_addr = 22'($urandom);
		last_block = 1;
		check_each = 1'($urandom);
		check_protect = 1'($urandom);
		n0 = erases;
		run(0, 1);
		cmp("status", exp_sr(f), status_reg);
		cmp("errs", {4'h0, f == 3'd1, f == 3'd2 && check_protect, f == 3'd4, f == 3'd3}, {4'h0, e_sup, e_pro, e_seq, e_era});
		cmp("addr", 8'h01, {7'h0, faddr === block_addr});
		cmp("cmd", 8'hff, last_cmd);
		cmp("erases", 8'h01, 8'(erases - n0));
		n0 = erases;
		if (e_sup || e_pro || e_seq || e_era) run(0, 0);
		cmp("refused", 8'(n0), 8'(erases));
		run(1, 0);
		cmp("cleared", 8'h80, {status_reg[7:6], 1'b0, e_sup, e_pro, e_seq, e_era, status_reg[0]});
		cmp("clear cmd", 8'h50, last_cmd);
	endtask : erase_one
	initial begin
		void'($urandom(48648));
		repeat (10) @(negedge mclk);
		reset = 0;
		cmp("reset", 8'h80, status_reg);
		for (int f = 0; f < 5; f++) erase_one(3'(f));
		repeat (6) erase_one(3'($urandom_range(4)));
		// Two erases with one deferred check: the failure must still show.
		fault = 3'd3;
		last_block = 0;
		check_each = 0;
		run(0, 1);
		cmp("deferred", 8'h00, {7'h0, e_era});
		cmp("cmd mid", 8'h70, last_cmd);
		fault = 3'd0;
		last_block = 1;
		run(0, 1);
		cmp("sticky", 8'ha1, {status_reg[7:1], e_era});
		run(1, 0);
		// Mid-sequence capture: a supply fault shows at once when each erase is checked.
		fault = 3'd1;
		last_block = 0;
		check_each = 1;
		run(0, 1);
		cmp("each", 8'h01, {7'h0, e_sup});
		cmp("poll cmd", 8'h70, last_cmd);
		run(1, 0);
		cmp("bus drive", 8'h00, 8'(bad_drive));
		wrap_up();
	end
endmodule : flash_block_erase_status_bench
`default_nettype wire
